// >>> design/cmul_pkg.sv
// package for the configurable signed multiplier slice: widths, register map, carriers
package cmul_pkg;

  // operand and product widths
  localparam int CMUL_WIDE_W = 18;
  localparam int CMUL_NARROW_W = 9;
  localparam int CMUL_PROD_W = 36;
  localparam int CMUL_HALF_PROD_W = 18;

  // apb register map (byte addresses)
  localparam int CMUL_ADDR_W = 12;
  localparam logic [11:0] CMUL_CTRL_OFF = 12'h000;
  localparam logic [11:0] CMUL_STATUS_OFF = 12'h004;
  localparam logic [11:0] CMUL_PROD_LO_OFF = 12'h008;
  localparam logic [11:0] CMUL_PROD_HI_OFF = 12'h00c;

  // control register fields
  localparam int CMUL_CTRL_NARROW_BIT = 0;
  localparam int CMUL_CTRL_IN_REG_BIT = 1;
  localparam int CMUL_CTRL_OUT_REG_BIT = 2;
  localparam logic [2:0] CMUL_CTRL_RESET = 3'h0;

  // status register fields
  localparam int CMUL_STAT_SIGNED_BIT = 0;
  localparam int CMUL_STAT_NARROW_BIT = 1;

  // operands and sign controls from the fabric travel together
  typedef struct packed {
    logic sign_a;
    logic sign_b;
    logic [17:0] a;
    logic [17:0] b;
  } cmul_ops_t;

  // configuration held in the control register
  typedef struct packed {
    logic out_reg;
    logic in_reg;
    logic narrow;
  } cmul_cfg_t;

endpackage : cmul_pkg

// >>> design/cmul_slice.sv
// configurable 18x18 / dual 9x9 signed-unsigned multiplier slice with apb control
`timescale 1ns/100ps
// Notes on behaviour
// - wide mode multiplies one pair of up-to-18-bit operands into one product.
// - narrow mode gives two independent 9x9 multipliers with separate products.
// - a sign control of 1 means two's complement, 0 means unsigned.
// - product is unsigned only if both operands unsigned, else signed.
// - one a-sign and one b-sign control serve both narrow halves.
// - sign controls may change at run time, no reconfiguration needed.
// - full-width product, never truncated or rounded, for any signedness.
// - operand inputs and products may each be registered or bypassed.
// - sign controls may be registered once with the operands.
// - all slice registers share one clock, clock enable and clear.
module cmul_slice
  import cmul_pkg::*;
(
  // clock and bus reset
  input wire logic clk_i,
  input wire logic reset_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [CMUL_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // slice register controls from the fabric
  input wire logic ena_i,
  input wire logic aclr_i,
  // operands and sign controls
  input wire cmul_ops_t ops_i,
  // product
  output logic [CMUL_PROD_W-1:0] product_o,
  output logic product_signed_o
);

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic helpers

  // wide product: sign-extend each operand by one bit, full 36-bit result
  function automatic logic [CMUL_PROD_W-1:0] mul_wide(input logic [17:0] a,
      input logic [17:0] b, input logic sa, input logic sb);
    logic signed [37:0] p;
    p = $signed({sa & a[17], a}) * $signed({sb & b[17], b});
    return p[CMUL_PROD_W-1:0];
  endfunction : mul_wide

  // narrow product: 9x9 with the same sign handling, 18-bit result
  function automatic logic [CMUL_HALF_PROD_W-1:0] mul_narrow(input logic [8:0] a,
      input logic [8:0] b, input logic sa, input logic sb);
    logic signed [19:0] p;
    p = $signed({sa & a[8], a}) * $signed({sb & b[8], b});
    return p[CMUL_HALF_PROD_W-1:0];
  endfunction : mul_narrow

  ////////////////////////////////////////////////////////////////////////////
  // apb control and status registers

  cmul_cfg_t cfg_reg, cfg_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic setup_phase;
  logic mapped;

  assign setup_phase = psel_i & ~penable_i;

  // decode, read mux and write; answer is registered so the access phase lasts one cycle
  always_comb begin
    cfg_next = cfg_reg;
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    mapped = (paddr_i == CMUL_CTRL_OFF) || (paddr_i == CMUL_STATUS_OFF) ||
             (paddr_i == CMUL_PROD_LO_OFF) || (paddr_i == CMUL_PROD_HI_OFF);
    if (setup_phase) begin
      pready_next = 1'b1;
      pslverr_next = ~mapped;
      prdata_next = 32'h0000_0000;
      case (paddr_i)
        CMUL_CTRL_OFF: prdata_next = {29'h0000_0000, cfg_reg};
        CMUL_STATUS_OFF: begin
          prdata_next[CMUL_STAT_SIGNED_BIT] = product_signed_o;
          prdata_next[CMUL_STAT_NARROW_BIT] = cfg_reg.narrow;
        end
        CMUL_PROD_LO_OFF: prdata_next = product_o[31:0];
        CMUL_PROD_HI_OFF: prdata_next = {28'h000_0000, product_o[CMUL_PROD_W-1:32]};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
    // write takes effect only at the completing edge of the access phase
    if (psel_i && penable_i && pready_reg && pwrite_i && paddr_i == CMUL_CTRL_OFF) begin
      cfg_next = cmul_cfg_t'(pwdata_i[2:0]);
    end
  end

  // bus registers use the synchronous bus reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_reg <= cmul_cfg_t'(CMUL_CTRL_RESET);
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // input stage: operands and sign controls, registered or bypassed

  cmul_ops_t ops_reg, ops_next;
  cmul_ops_t ops_use;
  logic [CMUL_PROD_W-1:0] prod_comb;
  logic signed_comb;

  // one enable for the whole slice; low holds every register
  always_comb begin
    ops_next = ena_i ? ops_i : ops_reg;
  end

  // sign controls sit in the same stage as the data so they stay aligned
  always_ff @(posedge clk_i or posedge aclr_i) begin
    if (aclr_i) begin
      ops_reg <= '0;
    end else begin
      ops_reg <= ops_next;
    end
  end

  // bypass muxes let the fabric trade latency for timing margin
  assign ops_use = cfg_reg.in_reg ? ops_reg : ops_i;

  ////////////////////////////////////////////////////////////////////////////
  // multiplier core

  // sign is per operand and applied afresh on every product, so it may change any cycle
  always_comb begin
    if (cfg_reg.narrow) begin
      // the single pair of sign controls drives both halves
      prod_comb[CMUL_HALF_PROD_W-1:0] = mul_narrow(ops_use.a[8:0], ops_use.b[8:0],
          ops_use.sign_a, ops_use.sign_b);
      prod_comb[CMUL_PROD_W-1:CMUL_HALF_PROD_W] = mul_narrow(ops_use.a[17:9],
          ops_use.b[17:9], ops_use.sign_a, ops_use.sign_b);
    end else begin
      prod_comb = mul_wide(ops_use.a, ops_use.b, ops_use.sign_a, ops_use.sign_b);
    end
    signed_comb = ops_use.sign_a | ops_use.sign_b;
  end

  ////////////////////////////////////////////////////////////////////////////
  // output stage: product registered or bypassed

  logic [CMUL_PROD_W-1:0] prod_reg, prod_next;
  logic signed_reg, signed_next;

  always_comb begin
    prod_next = ena_i ? prod_comb : prod_reg;
    signed_next = ena_i ? signed_comb : signed_reg;
  end

  // same clock, enable and clear as the input stage
  always_ff @(posedge clk_i or posedge aclr_i) begin
    if (aclr_i) begin
      prod_reg <= '0;
      signed_reg <= 1'b0;
    end else begin
      prod_reg <= prod_next;
      signed_reg <= signed_next;
    end
  end

  // in bypass the product is combinational from the operand path
  assign product_o = cfg_reg.out_reg ? prod_reg : prod_comb;
  assign product_signed_o = cfg_reg.out_reg ? signed_reg : signed_comb;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  logic bypass_all;
  assign bypass_all = ~cfg_reg.in_reg & ~cfg_reg.out_reg;

  wide_product_a: assert property (@(posedge clk_i) disable iff (aclr_i || reset_i)
    bypass_all && !cfg_reg.narrow |->
      product_o == mul_wide(ops_i.a, ops_i.b, ops_i.sign_a, ops_i.sign_b))
    else $error("wide product wrong");

  narrow_low_a: assert property (@(posedge clk_i) disable iff (aclr_i || reset_i)
    bypass_all && cfg_reg.narrow |->
      product_o[17:0] == mul_narrow(ops_i.a[8:0], ops_i.b[8:0], ops_i.sign_a, ops_i.sign_b))
    else $error("low narrow product wrong");

  narrow_high_a: assert property (@(posedge clk_i) disable iff (aclr_i || reset_i)
    bypass_all && cfg_reg.narrow |->
      product_o[35:18] == mul_narrow(ops_i.a[17:9], ops_i.b[17:9], ops_i.sign_a, ops_i.sign_b))
    else $error("high narrow product wrong");

  unsigned_full_a: assert property (@(posedge clk_i) disable iff (aclr_i || reset_i)
    bypass_all && !cfg_reg.narrow && !ops_i.sign_a && !ops_i.sign_b &&
      ops_i.a == 18'h3ffff && ops_i.b == 18'h3ffff |-> product_o == 36'hf_fff8_0001)
    else $error("unsigned full width product truncated");

  signed_minus_a: assert property (@(posedge clk_i) disable iff (aclr_i || reset_i)
    bypass_all && !cfg_reg.narrow && ops_i.sign_a && !ops_i.sign_b &&
      ops_i.a == 18'h3ffff && ops_i.b == 18'h00001 |-> product_o == 36'hf_ffff_ffff)
    else $error("signed operand not treated as negative");

  sign_flag_a: assert property (@(posedge clk_i) disable iff (aclr_i || reset_i)
    bypass_all |-> product_signed_o == (ops_i.sign_a | ops_i.sign_b))
    else $error("product sign flag wrong");

  input_stage_a: assert property (@(posedge clk_i) disable iff (aclr_i || reset_i)
    ena_i |=> ops_reg == $past(ops_i))
    else $error("input stage did not load operands and signs");

  output_pipe_a: assert property (@(posedge clk_i) disable iff (aclr_i || reset_i)
    cfg_reg.in_reg && cfg_reg.out_reg && !cfg_reg.narrow && ena_i ##1 ena_i && $stable(cfg_reg)
      |=> prod_reg == mul_wide($past(ops_i.a, 2), $past(ops_i.b, 2), $past(ops_i.sign_a, 2),
        $past(ops_i.sign_b, 2)))
    else $error("two stage product misaligned");

  enable_hold_a: assert property (@(posedge clk_i) disable iff (aclr_i || reset_i)
    !ena_i |=> $stable(ops_reg) && $stable(prod_reg) && $stable(signed_reg))
    else $error("slice register changed with enable low");

  clear_zero_a: assert property (@(posedge clk_i) disable iff (reset_i)
    aclr_i && $past(aclr_i) |-> ops_reg == '0 && prod_reg == '0 && !signed_reg)
    else $error("clear did not zero slice registers");

  // registered sign flag must travel with its product through the output stage
  sign_pipe_a: assert property (@(posedge clk_i) disable iff (aclr_i || reset_i)
    ena_i |=> signed_reg == $past(signed_comb))
    else $error("sign flag left its product");

  ////////////////////////////////////////////////////////////////////////////
  // bus assertions: the control register decides bypass and mode, so it must be exact

  // every setup cycle is answered by a registered ready one cycle later
  apb_ready_a: assert property (@(posedge clk_i) disable iff (reset_i)
    psel_i && !penable_i |=> pready_o)
    else $error("apb ready missing after setup");

  // ready is a single pulse so a back to back setup is not mistaken for an access
  apb_single_a: assert property (@(posedge clk_i) disable iff (reset_i)
    pready_o |=> !pready_o)
    else $error("apb ready longer than one cycle");

  // a control write lands at the completing edge of the access phase
  cfg_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == CMUL_CTRL_OFF |=>
      cfg_reg == cmul_cfg_t'($past(pwdata_i[2:0])))
    else $error("control write did not land");

  // control reads back what was written, upper bits zero
  ctrl_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
    psel_i && !penable_i && paddr_i == CMUL_CTRL_OFF |=>
      prdata_o == {29'h0000_0000, $past(cfg_reg)})
    else $error("control read back wrong");

  // addresses past the last register answer with an error and zero data
  unmapped_err_a: assert property (@(posedge clk_i) disable iff (reset_i)
    psel_i && !penable_i && paddr_i > CMUL_PROD_HI_OFF |=>
      pslverr_o && prdata_o == 32'h0000_0000)
    else $error("unmapped access not refused");

  // the four aligned registers never raise an error
  mapped_ok_a: assert property (@(posedge clk_i) disable iff (reset_i)
    psel_i && !penable_i && paddr_i <= CMUL_PROD_HI_OFF && paddr_i[1:0] == 2'h0 |=>
      !pslverr_o)
    else $error("mapped access flagged as error");

  // status bits mirror the live sign flag and mode, captured at the setup edge
  status_read_a: assert property (@(posedge clk_i) disable iff (aclr_i || reset_i)
    psel_i && !penable_i && paddr_i == CMUL_STATUS_OFF |=>
      prdata_o == {30'h0000_0000, $past(cfg_reg.narrow), $past(product_signed_o)})
    else $error("status read wrong");

  // high product word carries only the four top bits; reads are not atomic
  prod_high_a: assert property (@(posedge clk_i) disable iff (aclr_i || reset_i)
    psel_i && !penable_i && paddr_i == CMUL_PROD_HI_OFF |=>
      prdata_o == {28'h000_0000, $past(product_o[35:32])})
    else $error("high product word wrong");

  narrow_cov: cover property (@(posedge clk_i) cfg_reg.narrow && ops_i.sign_a && ena_i);
  wide_signed_cov: cover property (@(posedge clk_i) !cfg_reg.narrow && product_signed_o);
  piped_cov: cover property (@(posedge clk_i) cfg_reg.in_reg && cfg_reg.out_reg && ena_i ##1 ena_i);
  sign_change_cov: cover property (@(posedge clk_i) ena_i && $changed(ops_i.sign_b));
  clear_cov: cover property (@(posedge clk_i) $fell(aclr_i));

endmodule : cmul_slice

// >>> test/cmul_fabric.sv
// fabric-side model that presents operands and sign controls to the slice
`timescale 1ns/100ps
module cmul_fabric
  import cmul_pkg::*;
(
  // clock
  input wire logic clk_i,
  // operands toward the slice
  output cmul_ops_t ops_o
);
  // defined value from time zero so the slice never sees unknown operands
  initial ops_o = '0;

  // one sign control per operand, shared by both narrow halves
  task automatic put(input logic sa, input logic sb, input logic [17:0] a, input logic [17:0] b);
    @(posedge clk_i);
    ops_o <= {sa, sb, a, b};
  endtask : put
endmodule : cmul_fabric

// >>> test/cmul_slice_bench.sv
// self-checking bench for the multiplier slice
`timescale 1ns/100ps
module cmul_slice_bench;
  import cmul_pkg::*;
  logic clk_i = 1'h0, reset_i = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic ena = 1'h1, aclr = 1'h1, pready, pslverr, psgn;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [35:0] prod;
  cmul_ops_t ops;
  int error_cnt = 0, tests_run = 0;
  ////////////////////////////////////////
  // clock, fabric model and slice
  always #10 clk_i = ~clk_i;
  cmul_fabric fab (.clk_i(clk_i), .ops_o(ops));
  cmul_slice DUT (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .ena_i(ena), .aclr_i(aclr), .ops_i(ops),
    .product_o(prod), .product_signed_o(psgn));
  ////////////////////////////////////////
  // comparison and verdict
  task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  // reference product, widened so no sign combination can overflow
  function automatic logic [35:0] mul(input logic sa, input logic sb, input logic [17:0] a,
                                      input logic [17:0] b, input int w);
    logic signed [37:0] ea, eb, p;
    ea = {20'h0, a};
    eb = {20'h0, b};
    if (sa && a[w-1]) ea = ea - (38'sh1 <<< w);
    if (sb && b[w-1]) eb = eb - (38'sh1 <<< w);
    p = ea * eb;
    return p[35:0];
  endfunction : mul
  // apb transfer: hold the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_i);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) error_cnt++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  ////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    logic [31:0] rd;
    logic e;
    apb(1'h0, CMUL_CTRL_OFF, 32'h0, rd, e);
    check("ctrl reset", {4'h0, rd}, 36'h0);
    apb(1'h0, 12'h010, 32'h0, rd, e);
    check("unmapped error", {rd, 3'h0, e}, 36'h1);
  endtask : t_regs
  task automatic t_wide();
    logic [31:0] rd;
    logic e;
    apb(1'h1, CMUL_CTRL_OFF, 32'h0, rd, e);
    for (int s = 0; s < 4; s++) begin
      fab.put(s[1], s[0], 18'h20001, 18'h3fffe);
      #1;
      check("wide product", prod, mul(s[1], s[0], 18'h20001, 18'h3fffe, 18));
      check("wide sign", {35'h0, psgn}, {35'h0, s[1] | s[0]});
    end
  endtask : t_wide
  task automatic t_narrow();
    logic [35:0] hi, lo;
    logic [31:0] rd;
    logic e;
    apb(1'h1, CMUL_CTRL_OFF, 32'h1, rd, e);
    for (int s = 0; s < 4; s++) begin
      fab.put(s[1], s[0], 18'h202ff, 18'h3fc80);
      hi = mul(s[1], s[0], 18'h101, 18'h1fe, 9);
      lo = mul(s[1], s[0], 18'h0ff, 18'h080, 9);
      apb(1'h0, CMUL_STATUS_OFF, 32'h0, rd, e);
      check("narrow status", {4'h0, rd}, {34'h0, 1'h1, s[1] | s[0]});
      check("narrow product", prod, {hi[17:0], lo[17:0]});
      apb(1'h0, CMUL_PROD_LO_OFF, 32'h0, rd, e);
      check("product low", {4'h0, rd}, {4'h0, hi[13:0], lo[17:0]});
      apb(1'h0, CMUL_PROD_HI_OFF, 32'h0, rd, e);
      check("product high", {4'h0, rd}, {32'h0, hi[17:14]});
    end
  endtask : t_narrow
  // both stages registered: two edges of latency, frozen while enable is low
  task automatic t_pipe();
    logic [31:0] rd;
    logic e;
    apb(1'h1, CMUL_CTRL_OFF, 32'h6, rd, e);
    fab.put(1'h1, 1'h0, 18'h3ffff, 18'h00003);
    fab.put(1'h0, 1'h0, 18'h3ffff, 18'h00003);
    @(posedge clk_i);
    ena <= 1'h0;
    #1;
    check("pipe first", prod, mul(1'h1, 1'h0, 18'h3ffff, 18'h3, 18));
    check("pipe sign", {35'h0, psgn}, 36'h1);
    repeat (3) @(posedge clk_i);
    #1;
    check("pipe held", prod, mul(1'h1, 1'h0, 18'h3ffff, 18'h3, 18));
    @(posedge clk_i);
    ena <= 1'h1;
    @(posedge clk_i);
    #1;
    check("pipe second", prod, mul(1'h0, 1'h0, 18'h3ffff, 18'h3, 18));
    check("pipe sign", {35'h0, psgn}, 36'h0);
  endtask : t_pipe
  // clear must act between edges, not wait for one
  task automatic t_clr();
    @(posedge clk_i);
    aclr <= 1'h1;
    #1;
    check("clear product", prod, 36'h0);
    check("clear sign", {35'h0, psgn}, 36'h0);
    @(posedge clk_i);
    aclr <= 1'h0;
  endtask : t_clr
  ////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'h0;
    aclr <= 1'h0;
    t_regs();
    t_wide();
    t_narrow();
    t_pipe();
    t_clr();
    conclude();
  end
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
endmodule : cmul_slice_bench
